// File: cldbe_expander.sv
/*
 * Decode and expansion stage for compressed register-based loads/stores and
 * control transfers. Takes a parcel from fetch, reads operands from the
 * register file in the same cycle and hands a registered result to execute.
 * Assumes rs1Value/rs2Value answer rs1Idx/rs2Idx combinationally on the same
 * clock, and that execute holds execReady low to stall.
 */
// Behaviour
// [RULE1] Word load: address is base plus zero-extended offset times 4.
// [RULE2] Doubleword load/store only in 64/128-bit bases, offset times 8.
// [RULE3] Quadword load only in 128-bit base, offset times 16.
// [RULE4] Quadword store only in 128-bit base, offset times 16.
// [RULE5] Single float load/store only in 32-bit base with single float, times 4.
// [RULE6] Double float load/store only in 32/64-bit bases with double float, times 8.
// [RULE7] Word store writes compact source register to base plus offset times 4.
// [RULE8] Jump and branch offsets count 2-byte units; bit zero is zero.
// [RULE9] Plain jump adds sign-extended offset to pc, writes no link.
// [RULE10] Jump-and-link only in 32-bit base, also links pc plus 2.
// [RULE11] Register jump goes to full register value; zero register field is reserved. The target here has bit zero cleared.
// [RULE12] Register jump-and-link links pc plus 2; zero field decodes breakpoint.
// [RULE13] Compressed link values are pc plus 2, never plus 4.
// [RULE14] Branch-if-zero targets pc plus offset, taken when register is zero.
// [RULE15] Branch-if-nonzero uses same target, taken when register is nonzero.
// [RULE16] Compact fields select only eight base and eight data registers.
// [RULE17] Compact fields map to registers 8 to 15; offsets are reassembled.
// [RULE18] Reserved or unsupported-base encodings flag illegal instead of expanding.
`timescale 1ns/1ps
`default_nettype none

module cldbe_expander #(
    parameter int BASE_XLEN = 64,
    parameter bit HAS_F     = 1'b1,
    parameter bit HAS_D     = 1'b1
) (
    input  wire logic                           clk,
    input  wire logic                           arst_n,
    input  wire cldbe_pkg::cldbe_fetch_t        fetch,
    output logic                                fetchReady,
    output logic      [4:0]                     rs1Idx,
    output logic      [4:0]                     rs2Idx,
    input  wire logic [cldbe_pkg::XLEN-1:0]     rs1Value,
    input  wire logic [cldbe_pkg::XLEN-1:0]     rs2Value,
    input  wire logic                           execReady,
    output cldbe_pkg::cldbe_result_t            result
);

    localparam int XLEN = cldbe_pkg::XLEN;

    generate
        if (!(BASE_XLEN == 32 || BASE_XLEN == 64 || BASE_XLEN == 128)) begin : gBadBase
            $error("BASE_XLEN must be 32, 64 or 128");
        end
    endgenerate

    localparam bit IS32  = (BASE_XLEN == 32);
    localparam bit IS128 = (BASE_XLEN == 128);
    // Narrow bases wrap addresses and targets at their own width
    localparam logic [XLEN-1:0] ADDR_MASK = (BASE_XLEN == XLEN) ? {XLEN{1'b1}} :
        ((XLEN'(1) << BASE_XLEN) - XLEN'(1));

    logic [1:0]  quad;
    logic [2:0]  f3;
    logic [3:0]  f4;
    logic [4:0]  fullRs1;
    logic [4:0]  fullRs2;
    logic [4:0]  compactBase;
    logic [4:0]  compactData;
    logic [6:0]  wordOff;
    logic [7:0]  doubleOff;
    logic [8:0]  quadOff;
    logic [11:0] jumpOff;
    logic [8:0]  branchOff;

    assign quad    = fetch.instr[cldbe_pkg::QUAD_HI:cldbe_pkg::QUAD_LO];
    assign f3      = fetch.instr[cldbe_pkg::F3_HI:cldbe_pkg::F3_LO];
    assign f4      = fetch.instr[cldbe_pkg::F3_HI:cldbe_pkg::F4_LO];
    assign fullRs1 = fetch.instr[cldbe_pkg::RS1_HI:cldbe_pkg::RS1_LO];
    assign fullRs2 = fetch.instr[cldbe_pkg::RS2_HI:cldbe_pkg::RS2_LO];

    cldbe_reg_map uBaseMap (
        .field  (fetch.instr[cldbe_pkg::CRS1_HI:cldbe_pkg::CRS1_LO]),
        .regIdx (compactBase)
    );

    cldbe_reg_map uDataMap (
        .field  (fetch.instr[cldbe_pkg::CRS2_HI:cldbe_pkg::CRS2_LO]),
        .regIdx (compactData)
    );

    cldbe_imm_unpack uImm (
        .instr     (fetch.instr),
        .wordOff   (wordOff),
        .doubleOff (doubleOff),
        .quadOff   (quadOff),
        .jumpOff   (jumpOff),
        .branchOff (branchOff)
    );

    // Decode: classify the parcel into one operation or a flag
    cldbe_pkg::cldbe_op_t op;
    logic                 illegal;
    logic                 unclaimed;
    logic                 breakpoint;

    always_comb begin
        op         = cldbe_pkg::OP_NONE;
        illegal    = 1'b0;
        unclaimed  = 1'b0;
        breakpoint = 1'b0;
        unique case (quad)
            cldbe_pkg::QUAD0: begin
                unique case (f3)
                    cldbe_pkg::F3_LW: begin
                        op = cldbe_pkg::OP_WORD_LOAD; // [RULE1]
                    end
                    cldbe_pkg::F3_SW: begin
                        op = cldbe_pkg::OP_WORD_STORE; // [RULE7]
                    end
                    cldbe_pkg::F3_LD_FLW: begin
                        if (!IS32) begin
                            op = cldbe_pkg::OP_DOUBLE_LOAD; // [RULE2]
                        end else if (HAS_F) begin
                            op = cldbe_pkg::OP_FSINGLE_LOAD; // [RULE5]
                        end else begin
                            illegal = 1'b1; // [RULE18]
                        end
                    end
                    cldbe_pkg::F3_SD_FSW: begin
                        if (!IS32) begin
                            op = cldbe_pkg::OP_DOUBLE_STORE; // [RULE2]
                        end else if (HAS_F) begin
                            op = cldbe_pkg::OP_FSINGLE_STORE; // [RULE5]
                        end else begin
                            illegal = 1'b1; // [RULE18]
                        end
                    end
                    cldbe_pkg::F3_FLD_LQ: begin
                        if (IS128) begin
                            op = cldbe_pkg::OP_QUAD_LOAD; // [RULE3]
                        end else if (HAS_D) begin
                            op = cldbe_pkg::OP_FDOUBLE_LOAD; // [RULE6]
                        end else begin
                            illegal = 1'b1; // [RULE18]
                        end
                    end
                    cldbe_pkg::F3_FSD_SQ: begin
                        if (IS128) begin
                            op = cldbe_pkg::OP_QUAD_STORE; // [RULE4]
                        end else if (HAS_D) begin
                            op = cldbe_pkg::OP_FDOUBLE_STORE; // [RULE6]
                        end else begin
                            illegal = 1'b1; // [RULE18]
                        end
                    end
                    default: begin
                        unclaimed = 1'b1;
                    end
                endcase
            end
            cldbe_pkg::QUAD1: begin
                unique case (f3)
                    cldbe_pkg::F3_J: begin
                        op = cldbe_pkg::OP_JUMP; // [RULE9]
                    end
                    cldbe_pkg::F3_JAL: begin
                        // In wider bases this slot belongs to another decoder
                        if (IS32) begin
                            op = cldbe_pkg::OP_JUMP_LINK; // [RULE10]
                        end else begin
                            unclaimed = 1'b1;
                        end
                    end
                    cldbe_pkg::F3_BEQZ: begin
                        op = cldbe_pkg::OP_BRANCH_ZERO; // [RULE14]
                    end
                    cldbe_pkg::F3_BNEZ: begin
                        op = cldbe_pkg::OP_BRANCH_NONZERO; // [RULE15]
                    end
                    default: begin
                        unclaimed = 1'b1;
                    end
                endcase
            end
            cldbe_pkg::QUAD2: begin
                if (f4 == cldbe_pkg::F4_JR && fullRs2 == cldbe_pkg::ZERO_REG) begin
                    if (fullRs1 == cldbe_pkg::ZERO_REG) begin
                        illegal = 1'b1; // [RULE11] [RULE18]
                    end else begin
                        op = cldbe_pkg::OP_REG_JUMP; // [RULE11]
                    end
                end else if (f4 == cldbe_pkg::F4_JALR && fullRs2 == cldbe_pkg::ZERO_REG) begin
                    if (fullRs1 == cldbe_pkg::ZERO_REG) begin
                        breakpoint = 1'b1; // [RULE12]
                    end else begin
                        op = cldbe_pkg::OP_REG_JUMP_LINK; // [RULE12]
                    end
                end else begin
                    unclaimed = 1'b1;
                end
            end
            default: begin
                // A 32-bit instruction, not a compressed parcel
                unclaimed = 1'b1;
            end
        endcase
    end

    // Register file read ports; full-width field only for register jumps
    always_comb begin
        if (quad == cldbe_pkg::QUAD2) begin
            rs1Idx = fullRs1; // [RULE11]
        end else begin
            rs1Idx = compactBase; // [RULE16]
        end
        if (quad == cldbe_pkg::QUAD0) begin
            rs2Idx = compactData; // [RULE7]
        end else begin
            rs2Idx = cldbe_pkg::REG_FIELD_NONE;
        end
    end

    // Operand and target arithmetic
    logic [XLEN-1:0] memOff;
    logic [2:0]      memSize;
    logic            isLoad;
    logic            isStore;
    logic            isFloat;
    logic [XLEN-1:0] jumpSext;
    logic [XLEN-1:0] branchSext;
    logic [XLEN-1:0] baseValue;
    logic [XLEN-1:0] target;
    logic            redirect;
    logic            linkWrite;

    assign baseValue  = rs1Value & ADDR_MASK;
    assign jumpSext   = {{(XLEN-12){jumpOff[11]}}, jumpOff}; // [RULE8] [RULE9]
    assign branchSext = {{(XLEN-9){branchOff[8]}}, branchOff}; // [RULE8] [RULE14]

    always_comb begin
        memOff  = '0;
        memSize = cldbe_pkg::SIZE_NONE;
        isLoad  = 1'b0;
        isStore = 1'b0;
        isFloat = 1'b0;
        unique case (op)
            cldbe_pkg::OP_WORD_LOAD, cldbe_pkg::OP_WORD_STORE: begin
                memOff  = XLEN'(wordOff); // [RULE1] [RULE7]
                memSize = cldbe_pkg::SIZE_WORD;
            end
            cldbe_pkg::OP_FSINGLE_LOAD, cldbe_pkg::OP_FSINGLE_STORE: begin
                memOff  = XLEN'(wordOff); // [RULE5]
                memSize = cldbe_pkg::SIZE_WORD;
                isFloat = 1'b1;
            end
            cldbe_pkg::OP_DOUBLE_LOAD, cldbe_pkg::OP_DOUBLE_STORE: begin
                memOff  = XLEN'(doubleOff); // [RULE2]
                memSize = cldbe_pkg::SIZE_DOUBLE;
            end
            cldbe_pkg::OP_FDOUBLE_LOAD, cldbe_pkg::OP_FDOUBLE_STORE: begin
                memOff  = XLEN'(doubleOff); // [RULE6]
                memSize = cldbe_pkg::SIZE_DOUBLE;
                isFloat = 1'b1;
            end
            cldbe_pkg::OP_QUAD_LOAD, cldbe_pkg::OP_QUAD_STORE: begin
                memOff  = XLEN'(quadOff); // [RULE3] [RULE4]
                memSize = cldbe_pkg::SIZE_QUAD;
            end
            default: begin
                memOff  = '0;
            end
        endcase
        isLoad  = op inside {cldbe_pkg::OP_WORD_LOAD, cldbe_pkg::OP_DOUBLE_LOAD,
                             cldbe_pkg::OP_QUAD_LOAD, cldbe_pkg::OP_FSINGLE_LOAD,
                             cldbe_pkg::OP_FDOUBLE_LOAD};
        isStore = op inside {cldbe_pkg::OP_WORD_STORE, cldbe_pkg::OP_DOUBLE_STORE,
                             cldbe_pkg::OP_QUAD_STORE, cldbe_pkg::OP_FSINGLE_STORE,
                             cldbe_pkg::OP_FDOUBLE_STORE};
    end

    always_comb begin
        target    = '0;
        redirect  = 1'b0;
        linkWrite = 1'b0;
        unique case (op)
            cldbe_pkg::OP_JUMP: begin
                target   = fetch.pc + jumpSext; // [RULE9]
                redirect = 1'b1;
            end
            cldbe_pkg::OP_JUMP_LINK: begin
                target    = fetch.pc + jumpSext; // [RULE10]
                redirect  = 1'b1;
                linkWrite = 1'b1;
            end
            cldbe_pkg::OP_REG_JUMP: begin
                // Bit zero is dropped as for any register-indirect jump
                target   = rs1Value & ~XLEN'(1); // [RULE11]
                redirect = 1'b1;
            end
            cldbe_pkg::OP_REG_JUMP_LINK: begin
                target    = rs1Value & ~XLEN'(1); // [RULE12]
                redirect  = 1'b1;
                linkWrite = 1'b1;
            end
            cldbe_pkg::OP_BRANCH_ZERO: begin
                target   = fetch.pc + branchSext; // [RULE14]
                redirect = (baseValue == '0); // [RULE14]
            end
            cldbe_pkg::OP_BRANCH_NONZERO: begin
                target   = fetch.pc + branchSext; // [RULE15]
                redirect = (baseValue != '0); // [RULE15]
            end
            default: begin
                target = '0;
            end
        endcase
    end

    // Pipeline register toward execute
    logic accept;
    cldbe_pkg::cldbe_result_t next_result;

    assign fetchReady = !result.valid || execReady;
    assign accept     = fetch.valid && fetchReady;

    always_comb begin
        next_result = result;
        if (accept) begin
            next_result.valid      = 1'b1;
            next_result.illegal    = illegal; // [RULE18]
            next_result.unclaimed  = unclaimed;
            next_result.breakpoint = breakpoint; // [RULE12]
            // Flagged parcels carry no side effects downstream
            next_result.op         = op;
            next_result.pc         = fetch.pc;
            next_result.isLoad     = isLoad;
            next_result.isStore    = isStore;
            next_result.isFloatReg = isFloat;
            next_result.dataReg    = (isLoad || isStore) ? compactData
                                                         : cldbe_pkg::REG_FIELD_NONE;
            next_result.memSize    = memSize;
            next_result.memAddr    = (baseValue + memOff) & ADDR_MASK; // [RULE1] [RULE2]
            next_result.storeData  = isStore ? rs2Value : '0; // [RULE7]
            next_result.redirect   = redirect;
            next_result.target     = target & ADDR_MASK;
            next_result.linkWrite  = linkWrite;
            next_result.linkReg    = linkWrite ? cldbe_pkg::LINK_REG
                                               : cldbe_pkg::ZERO_REG; // [RULE9]
            next_result.linkValue  = linkWrite ?
                ((fetch.pc + cldbe_pkg::LINK_STEP) & ADDR_MASK) : '0; // [RULE10] [RULE13]
        end else if (execReady) begin
            next_result.valid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result <= '0;
        end else begin
            result <= next_result;
        end
    end

endmodule

`default_nettype wire

// File: cldbe_expander_props.sv
/* Concurrent checks on the expander's ports.
   Bound to cldbe_expander; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module cldbe_expander_props #(
    parameter int BASE_XLEN = 64
) (
    input wire logic                       clk,
    input wire logic                       arst_n,
    input wire cldbe_pkg::cldbe_fetch_t    fetch,
    input wire logic                       fetchReady,
    input wire logic [4:0]                 rs1Idx,
    input wire logic [4:0]                 rs2Idx,
    input wire logic [cldbe_pkg::XLEN-1:0] rs1Value,
    input wire logic [cldbe_pkg::XLEN-1:0] rs2Value,
    input wire logic                       execReady,
    input wire cldbe_pkg::cldbe_result_t   result
);
    logic         acc;
    logic [127:0] msk;
    logic [127:0] wAddr;
    assign acc = fetch.valid && fetchReady;
    assign msk = (BASE_XLEN >= 128) ? '1 : ((128'h1 << BASE_XLEN) - 128'h1);
    // Word offset rebuilt here so an address slip shows up a cycle later
    assign wAddr = (rs1Value + {121'h0, fetch.instr[5], fetch.instr[12:10],
                    fetch.instr[6], 2'h0}) & msk;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    resp_latency_a: assert property (acc |=> result.valid)
        else $error("accepted parcel gave no result");
    stall_hold_a: assert property (result.valid && !execReady |=> $stable(result))
        else $error("result moved during stall");
    word_addr_a: assert property (
        acc && fetch.instr[1:0] == 2'h0 && fetch.instr[15:13] == 3'h2
        |=> result.isLoad && result.memSize == 3'h2 && result.memAddr == $past(wAddr))
        else $error("word load address wrong");
    base_map_a: assert property (
        fetch.instr[1:0] != 2'h2 |-> rs1Idx == {2'h1, fetch.instr[9:7]})
        else $error("compact base index wrong");
    data_map_a: assert property (
        result.valid && (result.isLoad || result.isStore) |-> result.dataReg[4:3] == 2'h1)
        else $error("data register out of range");
    half_step_a: assert property (result.valid && result.redirect |-> !result.target[0])
        else $error("odd target");
    link_pc2_a: assert property (
        result.valid && result.linkWrite
        |-> result.linkReg == 5'h01 && result.linkValue == ((result.pc + 128'h2) & msk))
        else $error("link value wrong");
    brk_decode_a: assert property (
        acc && fetch.instr == 16'h9002 |=> result.breakpoint && !result.redirect)
        else $error("breakpoint not decoded");
    flag_quiet_a: assert property (
        result.illegal |-> !(result.isLoad || result.isStore || result.redirect))
        else $error("flagged parcel expanded");
    cover property (acc && fetch.instr[1:0] == 2'h0);
    cover property (result.valid && result.redirect);
    cover property (result.valid && !execReady);
endmodule
bind cldbe_expander cldbe_expander_props #(.BASE_XLEN(BASE_XLEN)) props (
    .clk(clk), .arst_n(arst_n), .fetch(fetch), .fetchReady(fetchReady),
    .rs1Idx(rs1Idx), .rs2Idx(rs2Idx), .rs1Value(rs1Value), .rs2Value(rs2Value),
    .execReady(execReady), .result(result));
`default_nettype wire

// File: cldbe_imm_unpack.sv
/*
 * Reassembles the scattered offset bits of the compact load/store, jump and
 * branch formats. Outputs are raw offsets; extension is left to the caller.
 * Assumes a 16-bit parcel on instr; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module cldbe_imm_unpack (
    input  wire logic [15:0] instr,
    output logic      [6:0]  wordOff,
    output logic      [7:0]  doubleOff,
    output logic      [8:0]  quadOff,
    output logic      [11:0] jumpOff,
    output logic      [8:0]  branchOff
);

    // Word: offset[5:3] in 12:10, offset[2] in 6, offset[6] in 5
    assign wordOff   = {instr[5], instr[12:10], instr[6], 2'h0}; // [RULE1] [RULE5] [RULE17]
    // Double: offset[5:3] in 12:10, offset[7:6] in 6:5
    assign doubleOff = {instr[6:5], instr[12:10], 3'h0}; // [RULE2] [RULE6] [RULE17]
    // Quad: offset[5:4] in 12:11, offset[8] in 10, offset[7:6] in 6:5
    assign quadOff   = {instr[10], instr[6:5], instr[12:11], 4'h0}; // [RULE3] [RULE4] [RULE17]

    // Jump offset[11|4|9:8|10|6|7|3:1|5] in 12:2, bit 0 always zero
    assign jumpOff   = {instr[12], instr[8], instr[10:9], instr[6], instr[7],
                        instr[2], instr[11], instr[5:3], 1'h0}; // [RULE8] [RULE17]
    // Branch offset[8|4:3] in 12:10, offset[7:6|2:1|5] in 6:2
    assign branchOff = {instr[12], instr[6:5], instr[2], instr[11:10],
                        instr[4:3], 1'h0}; // [RULE8] [RULE17]

endmodule

`default_nettype wire

// File: cldbe_pkg.sv
/*
 * Shared constants, operation codes and carrier structs for the compressed
 * load/store and control-transfer expander.
 * Assumes the instruction parcel is 16 bits with the quadrant in bits 1:0.
 */
package cldbe_pkg;

    // Datapath width covers the widest base; narrower bases are masked
    localparam int XLEN = 128;

    localparam logic [1:0] QUAD0 = 2'h0;
    localparam logic [1:0] QUAD1 = 2'h1;
    localparam logic [1:0] QUAD2 = 2'h2;

    // Field positions inside the 16-bit parcel
    localparam int QUAD_HI  = 1;
    localparam int QUAD_LO  = 0;
    localparam int F3_HI    = 15;
    localparam int F3_LO    = 13;
    localparam int F4_LO    = 12;
    localparam int RS1_HI   = 11;
    localparam int RS1_LO   = 7;
    localparam int RS2_HI   = 6;
    localparam int RS2_LO   = 2;
    localparam int CRS1_HI  = 9;
    localparam int CRS1_LO  = 7;
    localparam int CRS2_HI  = 4;
    localparam int CRS2_LO  = 2;

    // three_bit_function_field codes, quadrant 0
    localparam logic [2:0] F3_FLD_LQ  = 3'h1;
    localparam logic [2:0] F3_LW      = 3'h2;
    localparam logic [2:0] F3_LD_FLW  = 3'h3;
    localparam logic [2:0] F3_FSD_SQ  = 3'h5;
    localparam logic [2:0] F3_SW      = 3'h6;
    localparam logic [2:0] F3_SD_FSW  = 3'h7;
    // three_bit_function_field codes, quadrant 1
    localparam logic [2:0] F3_JAL     = 3'h1;
    localparam logic [2:0] F3_J       = 3'h5;
    localparam logic [2:0] F3_BEQZ    = 3'h6;
    localparam logic [2:0] F3_BNEZ    = 3'h7;
    // four_bit_function_field codes, quadrant 2
    localparam logic [3:0] F4_JR      = 4'h8;
    localparam logic [3:0] F4_JALR    = 4'h9;

    localparam logic [4:0] ZERO_REG          = 5'h00;
    localparam logic [4:0] LINK_REG          = 5'h01;
    localparam logic [4:0] COMPACT_REG_BASE  = 5'h08;
    localparam logic [4:0] REG_FIELD_NONE    = 5'h00;

    localparam logic [XLEN-1:0] LINK_STEP    = 128'h2;

    // Access size as log2 of bytes
    localparam logic [2:0] SIZE_NONE   = 3'h0;
    localparam logic [2:0] SIZE_WORD   = 3'h2;
    localparam logic [2:0] SIZE_DOUBLE = 3'h3;
    localparam logic [2:0] SIZE_QUAD   = 3'h4;

    typedef enum logic [16:0] {
        OP_NONE            = 17'h00001,
        OP_WORD_LOAD       = 17'h00002,
        OP_DOUBLE_LOAD     = 17'h00004,
        OP_QUAD_LOAD       = 17'h00008,
        OP_FSINGLE_LOAD    = 17'h00010,
        OP_FDOUBLE_LOAD    = 17'h00020,
        OP_WORD_STORE      = 17'h00040,
        OP_DOUBLE_STORE    = 17'h00080,
        OP_QUAD_STORE      = 17'h00100,
        OP_FSINGLE_STORE   = 17'h00200,
        OP_FDOUBLE_STORE   = 17'h00400,
        OP_JUMP            = 17'h00800,
        OP_JUMP_LINK       = 17'h01000,
        OP_REG_JUMP        = 17'h02000,
        OP_REG_JUMP_LINK   = 17'h04000,
        OP_BRANCH_ZERO     = 17'h08000,
        OP_BRANCH_NONZERO  = 17'h10000
    } cldbe_op_t;

    typedef struct packed {
        logic            valid;
        logic [15:0]     instr;
        logic [XLEN-1:0] pc;
    } cldbe_fetch_t;

    typedef struct packed {
        logic            valid;
        logic            illegal;
        logic            unclaimed;
        logic            breakpoint;
        cldbe_op_t       op;
        logic [XLEN-1:0] pc;
        logic            isLoad;
        logic            isStore;
        logic            isFloatReg;
        logic [4:0]      dataReg;
        logic [2:0]      memSize;
        logic [XLEN-1:0] memAddr;
        logic [XLEN-1:0] storeData;
        logic            redirect;
        logic [XLEN-1:0] target;
        logic            linkWrite;
        logic [4:0]      linkReg;
        logic [XLEN-1:0] linkValue;
    } cldbe_result_t;

endpackage

// File: cldbe_reg_map.sv
/*
 * Maps a 3-bit compact register field onto one of eight general registers.
 * Assumes the field is taken straight from the instruction parcel.
 */
`timescale 1ns/1ps
`default_nettype none

module cldbe_reg_map (
    input  wire logic [2:0] field,
    output logic      [4:0] regIdx
);

    // Compact fields reach only registers eight to fifteen
    assign regIdx = cldbe_pkg::COMPACT_REG_BASE | {2'h0, field}; // [RULE16] [RULE17]

endmodule

`default_nettype wire

// File: cldbe_regfile_model.sv
/* Register file stand-in for the expander's operand reads.
   Answers the indices combinationally, as the expander expects. */
`timescale 1ns/1ps
`default_nettype none
module cldbe_regfile_model (
    input  wire logic [4:0]   rs1Idx,
    input  wire logic [4:0]   rs2Idx,
    output logic      [127:0] rs1Value,
    output logic      [127:0] rs2Value
);
    // Register 9 holds zero so both branch outcomes can be reached
    assign rs1Value = (rs1Idx == 5'h09) ? '0 : {115'h0, rs1Idx, 8'h00};
    assign rs2Value = (rs2Idx == 5'h09) ? '0 : {115'h0, rs2Idx, 8'h00};
endmodule
`default_nettype wire

// File: tb_top.sv
/* Self-checking bench for the expander in a 64-bit base with float.
   Uses the register file stand-in; execute stalls only when a task says. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [127:0] PC = 128'h1000;
    logic                     clk = 1'b0;
    logic                     arst_n = 1'b0;
    logic                     execReady = 1'b1;
    logic                     fetchReady;
    logic [4:0]               rs1Idx;
    logic [4:0]               rs2Idx;
    logic [127:0]             rs1Value;
    logic [127:0]             rs2Value;
    cldbe_pkg::cldbe_fetch_t  fetch = '0;
    cldbe_pkg::cldbe_result_t res;
    int                       n_mismatch = 0;
    int                       compares = 0;
    always #10 clk = ~clk;
    cldbe_expander #(.BASE_XLEN(64), .HAS_F(1'b1), .HAS_D(1'b1)) dut (
        .clk(clk), .arst_n(arst_n), .fetch(fetch), .fetchReady(fetchReady),
        .rs1Idx(rs1Idx), .rs2Idx(rs2Idx), .rs1Value(rs1Value), .rs2Value(rs2Value),
        .execReady(execReady), .result(res));
    cldbe_regfile_model model (
        .rs1Idx(rs1Idx), .rs2Idx(rs2Idx), .rs1Value(rs1Value), .rs2Value(rs2Value));
    task automatic wrap_up;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [129:0] got, input logic [129:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Result is judged at the falling edge after the accepting edge
    task automatic issue(input logic [15:0] ins);
        int n;
        n = 0;
        @(negedge clk);
        fetch = '{valid: 1'b1, instr: ins, pc: PC};
        while (!fetchReady && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (n == 8) begin
            n_mismatch++;
            wrap_up();
        end
        @(negedge clk);
        fetch.valid = 1'b0;
    endtask
    task automatic t_mem;
        logic [2:0] f3 [6] = '{3'h2, 3'h6, 3'h3, 3'h7, 3'h1, 3'h5};
        for (int i = 0; i < 6; i++) begin
            issue({f3[i], 3'h7, 3'h2, 2'h3, 3'h4, 2'h0});
            chk(res.memAddr, (i < 2) ? 128'hA7C : 128'hAF8);
            chk(res.memSize, (i < 2) ? 3'h2 : 3'h3);
            chk(res.isStore, f3[i][2]);
            chk(res.isFloatReg, 1'(i > 3));
            chk(res.dataReg, 5'h0C);
            chk(res.storeData, f3[i][2] ? 128'hC00 : 128'h0);
        end
    endtask
    task automatic t_jump;
        issue(16'hBFFD);
        chk(res.target, PC - 128'h2);
        chk(res.linkWrite, 1'b0);
        issue(16'hAFFD);
        chk(res.target, PC + 128'h7FE);
        issue(16'h2FFD);
        chk(res.unclaimed, 1'b1);
        chk(res.linkWrite, 1'b0);
    endtask
    task automatic t_regjump;
        issue(16'h8502);
        chk({res.redirect, res.linkWrite, res.target}, {2'h2, 128'hA00});
        issue(16'h9502);
        chk(res.linkValue, PC + 128'h2);
        chk(res.target, 128'hA00);
        issue(16'h8002);
        chk({res.illegal, res.redirect}, 2'h2);
        issue(16'h9002);
        chk({res.breakpoint, res.redirect}, 2'h2);
    endtask
    task automatic t_branch;
        logic [15:0]  ins [5] = '{16'hCCFD, 16'hCD7D, 16'hECFD, 16'hED7D, 16'hD081};
        logic [4:0]   take = 5'h13;
        for (int i = 0; i < 5; i++) begin
            issue(ins[i]);
            chk(res.redirect, take[4-i]);
            chk(res.target, (i < 4) ? PC + 128'hFE : PC - 128'h100);
        end
    endtask
    // Stall must hold the result and refuse new parcels until released
    task automatic t_stall;
        @(negedge clk);
        execReady = 1'b0;
        issue({3'h2, 3'h7, 3'h2, 2'h3, 3'h4, 2'h0});
        chk(fetchReady, 1'b0);
        @(negedge clk);
        chk({res.valid, res.memAddr}, {1'b1, 128'hA7C});
        execReady = 1'b1;
        @(negedge clk);
        chk(res.valid, 1'b0);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        t_mem();
        t_jump();
        t_regjump();
        t_branch();
        t_stall();
        wrap_up();
    end
endmodule
`default_nettype wire
